// [verilog/pss_pkg.sv]
package pss_pkg;

    // ------------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------------
    localparam int unsigned PSS_ADDR_W = 20;
    localparam int unsigned PSS_LANES  = 4;
    localparam int unsigned PSS_LANE_W = 8;
    localparam int unsigned PSS_CELL_W = PSS_LANE_W + 1;

    // ------------------------------------------------------------------
    // Burst counter
    // ------------------------------------------------------------------
    localparam int unsigned PSS_BURST_W    = 2;
    localparam logic [1:0]  PSS_IDX_START  = 2'h0;
    localparam logic [1:0]  PSS_IDX_STEP   = 2'h1;
    localparam logic        PSS_ORDER_LINE = 1'b0;

    // ------------------------------------------------------------------
    // Selection state
    // ------------------------------------------------------------------
    typedef enum logic {
        PSS_DESELECTED = 1'b0,
        PSS_SELECTED   = 1'b1
    } pss_sel_type;

endpackage : pss_pkg

// [verilog/pss_lane_ram.sv]
`timescale 1ns/1ps
module pss_lane_ram #(
    parameter int unsigned ADDR_W = 20,
    parameter int unsigned LANES  = 4,
    parameter int unsigned CELL_W = 9
) (
    // Clock
    input  wire logic                    clk_sys,
    // Access
    input  wire logic [ADDR_W-1:0]       access_addr,
    input  wire logic                    read_en,
    input  wire logic [LANES-1:0]        write_lanes,
    input  wire logic [LANES*CELL_W-1:0] write_word,
    // Read data
    output logic      [LANES*CELL_W-1:0] read_word
);

    // ------------------------------------------------------------------
    // One array per lane so a byte write leaves its neighbours untouched.
    // ------------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++) begin : g_lane
            logic [CELL_W-1:0] cells [0:(1<<ADDR_W)-1];
            always_ff @(posedge clk_sys) begin
                if (write_lanes[lane]) begin
                    cells[access_addr] <= write_word[lane*CELL_W +: CELL_W];
                end
                if (read_en) begin
                    read_word[lane*CELL_W +: CELL_W] <= cells[access_addr];
                end
            end
        end
    endgenerate

endmodule : pss_lane_ram

// [verilog/pss_sram_port.sv]
`timescale 1ns/1ps
module pss_sram_port
    import pss_pkg::*;
#(
    parameter int unsigned AW                 = PSS_ADDR_W,
    parameter int unsigned LANES              = PSS_LANES,
    parameter int unsigned LANE_W             = PSS_LANE_W,
    parameter bit          HAS_SELECT_EXPAND_LOW = 1'b1
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Address and strobes
    input  wire logic [AW-1:0]       addr,
    input  wire logic                cpu_addr_strobe_n,
    input  wire logic                ctl_addr_strobe_n,
    input  wire logic                burst_step_n,
    // Chip selects
    input  wire logic                select_primary_n,
    input  wire logic                select_expand_high,
    input  wire logic                select_expand_low_n,
    // Write controls
    input  wire logic                all_lanes_write_n,
    input  wire logic                lane_write_gate_n,
    input  wire logic [LANES-1:0]    lane_write_select_n,
    // Asynchronous and static pins
    input  wire logic                out_enable_n,
    input  wire logic                sleep_request,
    input  wire logic                burst_order_sel,
    // Data and parity lines
    input  wire logic [LANES*LANE_W-1:0] data_in,
    input  wire logic [LANES-1:0]    parity_lines_in,
    output logic      [LANES*LANE_W-1:0] data_out,
    output logic      [LANES-1:0]    parity_lines_out,
    output logic                     data_oe
);

    localparam int unsigned DW     = LANES * LANE_W;
    localparam int unsigned CELL_W = LANE_W + 1;
    localparam int unsigned WW     = LANES * CELL_W;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [AW-1:0]          addr_q;
        logic                   sel1_n_q;
        logic                   sel2_q;
        logic                   sel3_n_q;
        logic                   cpu_n_q;
        logic                   ctl_n_q;
        logic                   step_n_q;
        logic                   all_n_q;
        logic                   gate_n_q;
        logic [LANES-1:0]       lsel_n_q;
        logic [DW-1:0]          din_q;
        logic [LANES-1:0]       pin_q;
        logic                   oe_meta;
        logic                   oe_sync;
        logic                   slp_meta;
        logic                   slp_sync;
        logic                   mode_meta;
        logic                   mode_sync;
        pss_sel_type            sel_state;
        logic [AW-1:0]          base_addr;
        logic [PSS_BURST_W-1:0] start_bits;
        logic [PSS_BURST_W-1:0] idx;
        logic                   rd_valid;
        logic                   rd_first;
        logic [DW-1:0]          dout;
        logic [LANES-1:0]       pout;
        logic                   oe_out;
    } pss_port_state_type;

    pss_port_state_type state_reg;
    pss_port_state_type state_next;

    logic [AW-1:0]    acc_addr;
    logic             acc_read;
    logic [LANES-1:0] acc_lanes;
    logic [WW-1:0]    wr_word;
    logic [WW-1:0]    rd_word;
    logic [DW-1:0]    rd_data;
    logic [LANES-1:0] rd_par;

    // ------------------------------------------------------------------
    // Lane packing: each cell holds a data byte and its parity bit.
    // ------------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++) begin : g_pack
            assign wr_word[lane*CELL_W +: CELL_W] =
                {state_reg.pin_q[lane], state_reg.din_q[lane*LANE_W +: LANE_W]};
            assign rd_data[lane*LANE_W +: LANE_W] = rd_word[lane*CELL_W +: LANE_W];
            assign rd_par[lane] = rd_word[lane*CELL_W + LANE_W];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic                   load_cpu;
        logic                   load_ctl;
        logic                   chosen;
        logic                   access;
        logic [PSS_BURST_W-1:0] bits;
        logic [LANES-1:0]       lanes;
        load_cpu   = 1'b0;
        load_ctl   = 1'b0;
        chosen     = 1'b0;
        access     = 1'b0;
        bits       = '0;
        lanes      = '0;
        state_next = state_reg;

        // Synchronous pins: one input register each.
        state_next.addr_q   = addr;
        state_next.sel1_n_q = select_primary_n;
        state_next.sel2_q   = select_expand_high;
        state_next.sel3_n_q = select_expand_low_n;
        state_next.cpu_n_q  = cpu_addr_strobe_n;
        state_next.ctl_n_q  = ctl_addr_strobe_n;
        state_next.step_n_q = burst_step_n;
        state_next.all_n_q  = all_lanes_write_n;
        state_next.gate_n_q = lane_write_gate_n;
        state_next.lsel_n_q = lane_write_select_n;
        state_next.din_q    = data_in;
        state_next.pin_q    = parity_lines_in;

        // Asynchronous and static pins pass two flip-flops first.
        state_next.oe_meta   = out_enable_n;
        state_next.oe_sync   = state_reg.oe_meta;
        state_next.slp_meta  = sleep_request;
        state_next.slp_sync  = state_reg.slp_meta;
        state_next.mode_meta = burst_order_sel;
        state_next.mode_sync = state_reg.mode_meta;

        // Address strobes; sleep blocks any new access.
        load_cpu = !state_reg.cpu_n_q && !state_reg.sel1_n_q
                   && !state_reg.slp_sync;
        load_ctl = !state_reg.ctl_n_q && !load_cpu
                   && !state_reg.slp_sync;
        chosen   = !state_reg.sel1_n_q && state_reg.sel2_q
                   && (!state_reg.sel3_n_q || !HAS_SELECT_EXPAND_LOW);

        if (load_cpu || load_ctl) begin
            // Selects matter only here, never during a burst.
            state_next.sel_state  = chosen ? PSS_SELECTED : PSS_DESELECTED;
            state_next.base_addr  = state_reg.addr_q;
            state_next.start_bits = state_reg.addr_q[PSS_BURST_W-1:0];
            state_next.idx        = PSS_IDX_START;
        end else if (state_reg.sel_state == PSS_SELECTED && !state_reg.step_n_q) begin
            state_next.idx = state_reg.idx + PSS_IDX_STEP;
        end

        if (state_reg.mode_sync == PSS_ORDER_LINE) begin
            bits = state_next.start_bits + state_next.idx;
        end else begin
            bits = state_next.start_bits ^ state_next.idx;
        end

        if (!state_reg.all_n_q) begin
            lanes = '1;
        end else if (!state_reg.gate_n_q) begin
            lanes = ~state_reg.lsel_n_q;
        end

        // A processor strobe cycle ignores write controls; its write lands
        // on the following clock at the same address.
        access    = state_next.sel_state == PSS_SELECTED && !state_reg.slp_sync;
        acc_addr  = {state_next.base_addr[AW-1:PSS_BURST_W], bits};
        acc_lanes = (access && !load_cpu) ? lanes : '0;
        acc_read  = access && !(|acc_lanes);

        // Read pipeline: the cell register then the output register.
        state_next.rd_valid = acc_read;
        state_next.rd_first = acc_read && (load_cpu || load_ctl)
                              && state_reg.sel_state == PSS_DESELECTED;
        state_next.dout     = rd_data;
        state_next.pout     = rd_par;
        state_next.oe_out   = state_reg.rd_valid && !state_reg.rd_first
                              && !state_reg.oe_sync
                              && !state_reg.slp_sync;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.sel1_n_q  <= 1'b1;
            state_reg.cpu_n_q   <= 1'b1;
            state_reg.ctl_n_q   <= 1'b1;
            state_reg.step_n_q  <= 1'b1;
            state_reg.all_n_q   <= 1'b1;
            state_reg.gate_n_q  <= 1'b1;
            state_reg.lsel_n_q  <= '1;
            state_reg.oe_meta   <= 1'b1;
            state_reg.oe_sync   <= 1'b1;
            state_reg.mode_meta <= 1'b1;
            state_reg.mode_sync <= 1'b1;
            state_reg.sel_state <= PSS_DESELECTED;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    pss_lane_ram #(
        .ADDR_W (AW),
        .LANES  (LANES),
        .CELL_W (CELL_W)
    ) u_ram (
        .clk_sys     (clk_sys),
        .access_addr (acc_addr),
        .read_en     (acc_read),
        .write_lanes (acc_lanes),
        .write_word  (wr_word),
        .read_word   (rd_word)
    );

    // Outputs come from flip-flops, so the enable trails the pin by the
    // synchroniser; a true asynchronous release needs a pad-level gate.
    assign data_out         = state_reg.dout;
    assign parity_lines_out = state_reg.pout;
    assign data_oe          = state_reg.oe_out;

endmodule : pss_sram_port

// [dv/pss_sram_port_checker.sv]
`timescale 1ns/1ps
module pss_sram_port_checker #(
    parameter int unsigned LANES  = 4,
    parameter int unsigned LANE_W = 8
) (
    // Clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rst,
    // Strobes, selects and writes
    input wire logic                    cpu_addr_strobe_n,
    input wire logic                    ctl_addr_strobe_n,
    input wire logic                    select_primary_n,
    input wire logic                    select_expand_high,
    input wire logic                    select_expand_low_n,
    input wire logic                    all_lanes_write_n,
    input wire logic                    lane_write_gate_n,
    input wire logic [LANES-1:0]        lane_write_select_n,
    // Asynchronous pins
    input wire logic                    out_enable_n,
    input wire logic                    sleep_request,
    // Outputs
    input wire logic [LANES*LANE_W-1:0] data_out,
    input wire logic                    data_oe
);
    logic sel_ok, ctl_ld, rd_ok, quiet;
    assign sel_ok = !select_primary_n && select_expand_high && !select_expand_low_n;
    assign ctl_ld = !ctl_addr_strobe_n && cpu_addr_strobe_n;
    assign rd_ok  = ctl_ld && sel_ok && all_lanes_write_n && lane_write_gate_n;
    assign quiet  = !out_enable_n && !sleep_request;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Windows are generous because enable and sleep pass two synchroniser stages.
    a_read_drives_bus: assert property ((rd_ok && quiet)[*5] |=> data_oe)
        else $error("read did not drive the lines");
    a_first_read_masked: assert property ((ctl_ld && !sel_ok) ##1 rd_ok |-> ##3 !data_oe)
        else $error("first read after deselect drove");
    a_deselect_releases: assert property ((ctl_ld && !sel_ok) |-> ##3 !data_oe)
        else $error("deselected port drove");
    a_cpu_strobe_ignored: assert property ((!cpu_addr_strobe_n && !ctl_addr_strobe_n
        && select_primary_n) |-> ##3 !data_oe)
        else $error("ignored strobe selected the port");
    a_global_write_quiet: assert property ((ctl_ld && !all_lanes_write_n) |-> ##3 !data_oe)
        else $error("drove during global write");
    a_lane_write_quiet: assert property ((ctl_ld && !lane_write_gate_n
        && !(&lane_write_select_n)) |-> ##3 !data_oe)
        else $error("drove during lane write");
    a_enable_releases: assert property (out_enable_n[*5] |-> !data_oe)
        else $error("drove with enable high");
    a_sleep_holds: assert property (sleep_request[*8] |-> !data_oe && $stable(data_out))
        else $error("activity during sleep");
    c_read_run: cover property ((rd_ok && quiet)[*5]);
    c_deselect: cover property ((ctl_ld && !sel_ok) ##1 rd_ok);
    c_sleep: cover property (sleep_request[*8]);
endmodule : pss_sram_port_checker

// [dv/pss_bus_master.sv]
`timescale 1ns/1ps
module pss_bus_master (
    // Clock
    input  wire logic        clk_sys,
    // Master drive
    input  wire logic        mst_drive,
    input  wire logic [35:0] mst_word,
    // Device side
    input  wire logic [31:0] data_out,
    input  wire logic [3:0]  parity_lines_out,
    input  wire logic        data_oe,
    output logic      [31:0] data_in,
    output logic      [3:0]  parity_lines_in
);
    logic [35:0] last_reg;
    // A released line shows the inverse of its last level, so stale data never passes.
    always_comb begin
        if (mst_drive && data_oe) begin
            {parity_lines_in, data_in} = {36{1'bx}};
        end else if (mst_drive) begin
            {parity_lines_in, data_in} = mst_word;
        end else if (data_oe) begin
            {parity_lines_in, data_in} = {parity_lines_out, data_out};
        end else begin
            {parity_lines_in, data_in} = ~last_reg;
        end
    end
    always_ff @(posedge clk_sys) begin
        last_reg <= {parity_lines_in, data_in};
    end
endmodule : pss_bus_master

// [dv/pss_sram_port_tb_top.sv]
`timescale 1ns/1ps
module pss_sram_port_tb_top;
    logic        clk_sys, rst, cpu_addr_strobe_n, ctl_addr_strobe_n, burst_step_n;
    logic        select_primary_n, select_expand_high, select_expand_low_n, skip;
    logic        all_lanes_write_n, lane_write_gate_n, out_enable_n, sleep_request;
    logic        burst_order_sel, data_oe, mst_drive, m_sel, e_oe, e_rd;
    logic [3:0]  lane_write_select_n, parity_lines_in, parity_lines_out;
    logic [19:0] addr, m_base;
    logic [31:0] data_in, data_out;
    logic [35:0] mst_word, e_w;
    logic [1:0]  m_idx;
    logic [35:0] mem [int];
    logic [35:0] x_w [int];
    logic        x_oe [int];
    logic        x_rd [int];
    logic        x_ck [int];
    logic [4:0]  pick [5] = '{5'h00, 5'h12, 5'h16, 5'h06, 5'h02};
    int          n, cycles, err_total, num_checks, seed;

    pss_sram_port u_pss_sram_port (.clk_sys, .rst, .addr, .cpu_addr_strobe_n,
        .ctl_addr_strobe_n, .burst_step_n, .select_primary_n, .select_expand_high,
        .select_expand_low_n, .all_lanes_write_n, .lane_write_gate_n, .lane_write_select_n,
        .out_enable_n, .sleep_request, .burst_order_sel, .data_in, .parity_lines_in,
        .data_out, .parity_lines_out, .data_oe);
    pss_bus_master u_pss_bus_master (.clk_sys, .mst_drive, .mst_word, .data_out,
        .parity_lines_out, .data_oe, .data_in, .parity_lines_in);

    always #10 clk_sys = ~clk_sys;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 3000) begin
            err_total++;
            final_report();
        end
    end

    task automatic cmp_bit(string what, logic exp, logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_word(string what, logic [35:0] exp, logic [35:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word

    function automatic void model();
        logic        cpu_ld, load, first;
        logic [3:0]  wl;
        logic [19:0] a;
        logic [35:0] w;
        cpu_ld = !cpu_addr_strobe_n && !select_primary_n;
        load = !sleep_request && (cpu_ld || !ctl_addr_strobe_n);
        first = 1'b0;
        e_oe = 1'b0;
        e_rd = 1'b0;
        if (load) begin
            first = !m_sel;
            m_sel = !select_primary_n && select_expand_high && !select_expand_low_n;
            first = first && m_sel;
            m_base = addr;
            m_idx = 2'h0;
        end else if (m_sel && !burst_step_n && !sleep_request) begin
            m_idx = m_idx + 2'h1;
        end
        a = m_base;
        a[1:0] = burst_order_sel ? m_base[1:0] ^ m_idx : m_base[1:0] + m_idx;
        wl = !all_lanes_write_n ? 4'hf : (lane_write_gate_n ? 4'h0 : ~lane_write_select_n);
        if (cpu_ld) wl = 4'h0;
        if (m_sel && !sleep_request) begin
            w = mem[a];
            for (int i = 0; i < 4; i++) begin
                if (wl[i]) {w[32+i], w[8*i +: 8]} = {mst_word[32+i], mst_word[8*i +: 8]};
            end
            mem[a] = w;
            e_rd = (wl == 4'h0);
            e_w = w;
            e_oe = e_rd && !first && !out_enable_n;
        end
    endfunction : model

    task automatic tick();
        model();
        {x_ck[n], x_rd[n], x_oe[n], x_w[n]} = {!skip, e_rd, e_oe, e_w};
        @(posedge clk_sys);
        #1;
        if (n >= 2 && x_ck[n-2]) begin
            cmp_bit("data_oe", x_oe[n-2], data_oe);
            if (x_rd[n-2]) cmp_word("read", x_w[n-2], {parity_lines_out, data_out});
        end
        n++;
    endtask : tick

    task automatic rnd(logic wr, int md);
        logic [31:0] r;
        r = $random(seed);
        {cpu_addr_strobe_n, ctl_addr_strobe_n} = {r[1:0] != 2'h0, r[3:2] != 2'h0};
        select_primary_n = r[6:4] == 3'h0;
        select_expand_high = r[9:7] != 3'h0;
        select_expand_low_n = r[12:10] == 3'h0;
        if (md != 0) begin
            {cpu_addr_strobe_n, ctl_addr_strobe_n, select_primary_n, select_expand_high,
                select_expand_low_n} = pick[md];
        end
        burst_step_n = wr || r[13];
        addr = {14'h0, r[19:14]};
        all_lanes_write_n = !wr || r[21:20] != 2'h0;
        lane_write_gate_n = !wr || r[22];
        lane_write_select_n = r[27:24];
        mst_drive = wr;
        mst_word = {r[31:28], 32'($random(seed))};
        tick();
    endtask : rnd

    task automatic pad(int k, logic oe);
        out_enable_n = oe;
        skip = 1'b1;
        mst_drive = 1'b0;
        repeat (k) begin
            {cpu_addr_strobe_n, ctl_addr_strobe_n, burst_step_n} = 3'h7;
            {all_lanes_write_n, lane_write_gate_n} = 2'h3;
            tick();
        end
        skip = 1'b0;
    endtask : pad

    task automatic do_reset(logic ord);
        {x_ck[n-1], x_ck[n-2]} = 2'h0;
        rst = 1'b1;
        burst_order_sel = ord;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        m_sel = 1'b0;
        pad(5, 1'b1);
    endtask : do_reset

    task automatic phases(int k);
        repeat (k) begin
            pad(5, 1'b0);
            rnd(1'b0, 2);
            repeat (6) rnd(1'b0, 1);
            rnd(1'b0, 3);
            repeat (40) rnd(1'b0, 0);
            pad(5, 1'b1);
            repeat (3) begin
                rnd(1'b1, 4);
                rnd(1'b1, 0);
            end
            repeat (30) rnd(1'b1, 0);
        end
    endtask : phases

    initial begin
        {clk_sys, rst, skip, sleep_request, mst_drive, burst_order_sel} = 6'h19;
        {n, cycles, err_total, num_checks, seed} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h9941};
        {cpu_addr_strobe_n, ctl_addr_strobe_n, burst_step_n, out_enable_n} = 4'hf;
        {all_lanes_write_n, lane_write_gate_n, lane_write_select_n} = 6'h3f;
        {select_primary_n, select_expand_high, select_expand_low_n} = 3'h2;
        {addr, mst_word} = 56'h0;
        do_reset(1'b1);
        for (int i = 0; i < 64; i++) begin
            {ctl_addr_strobe_n, all_lanes_write_n, mst_drive, addr} = {3'h1, 20'(i)};
            mst_word = {4'(i), 32'($random(seed))};
            tick();
        end
        phases(3);
        sleep_request = 1'b1;
        pad(10, 1'b0);
        sleep_request = 1'b0;
        pad(6, 1'b0);
        repeat (30) rnd(1'b0, 0);
        do_reset(1'b0);
        phases(2);
        pad(3, 1'b0);
        final_report();
    end
endmodule : pss_sram_port_tb_top

bind pss_sram_port pss_sram_port_checker #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (.clk_sys,
    .rst, .cpu_addr_strobe_n, .ctl_addr_strobe_n, .select_primary_n, .select_expand_high,
    .select_expand_low_n, .all_lanes_write_n, .lane_write_gate_n, .lane_write_select_n,
    .out_enable_n, .sleep_request, .data_out, .data_oe);
